// ==== uart_isr_lcr_consts.vh ====
// constants for the interrupt identification and line format block
`ifndef UART_ID_FORMAT_CONSTS_VH
`define UART_ID_FORMAT_CONSTS_VH
// register addresses (byte offsets, 3-bit port)
`define ADDR_INT_ID 3'h2
`define ADDR_LINE_FMT 3'h3
`define ADDR_EN_FEAT 3'h4
`define ADDR_SRC_EN 3'h5
`define ADDR_FIFO_EN 3'h6
// source index (0 = highest priority)
`define SRC_LINE_ERR 0
`define SRC_RX_DATA 1
`define SRC_RX_TIMEOUT 2
`define SRC_TX_EMPTY 3
`define SRC_MODEM 4
`define SRC_XOFF 5
`define SRC_FLOW 6
`define NUM_SRC 7
// identification codes, bits 5..0
`define CODE_LINE_ERR 6'h06
`define CODE_RX_DATA 6'h04
`define CODE_RX_TIMEOUT 6'h0c
`define CODE_TX_EMPTY 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_FLOW 6'h20
`define CODE_NONE 6'h01
`define CODE_CLEAR 6'h00
// line format control fields
`define LFC_DIV_EN 7
`define LFC_BREAK 6
`define LFC_FORCE 5
`define LFC_EVEN 4
`define LFC_PAR_EN 3
`define LFC_STOP 2
`define LFC_WLEN_HI 1
`define LFC_WLEN_LO 0
`define LFC_RESET 8'h00
// enhanced feature field that enables ids 5..4
`define ENH_FEAT_BIT 4
`define ENH_FEAT_RESET 8'h00
`define SRC_EN_RESET 8'h00
`define FIFO_EN_BIT 0
`define FIFO_RESET 1'b0
`define RDATA_IDLE 8'h00
// stop length in half bit times
`define STOP_HALF_1 2'h2
`define STOP_HALF_15 2'h3
`define STOP_HALF_2 2'h0
`define WLEN_5 2'h0
`define WLEN_6 2'h1
`define WLEN_7 2'h2
`define DBITS_5 4'h5
`define DBITS_6 4'h6
`define DBITS_7 4'h7
`define DBITS_8 4'h8
`endif

// ==== uart_irq_status_line_format.v ====
// interrupt identification and line format control of one serial channel
// How it works
// [RULE_01] six priority levels; an id read returns the highest pending code
// [RULE_02] reported source stays latched until serviced, others not acknowledged
// [RULE_03] id read clears only the reported source; next read shows lower one
// [RULE_04] line status error code: bits 2 and 1 set
// [RULE_05] rx data code bit 2; rx timeout bits 3 and 2, same level; code ranks rx data above rx timeout
// [RULE_06] tx empty sets bit 1 only; modem change reads all code bits zero
// [RULE_07] xoff or special character reported at level five with bit 4
// [RULE_08] cts/rts change reported at level six with bit 5
// [RULE_09] id bits 5 and 4 only active with enhanced bit 4 set
// [RULE_10] xoff indication held until a matching xon is received
// [RULE_11] id bits 7 and 6 read one when fifos enabled, else zero
// [RULE_12] id bit 0 low when pending, high otherwise and after reset
// [RULE_13] format bit 7 opens divisor latches and enhanced register
// [RULE_14] format bit 6 forces transmit line low until cleared
// [RULE_15] forced parity: bit 4 zero gives one, bit 4 one gives zero
// [RULE_16] unforced parity: bit 4 zero odd, one even, over data bits
// [RULE_17] format bit 3 enables parity generation and checking
// [RULE_18] format bit 2 sets stop length with word length, resets zero
// [RULE_19] format bits 1..0 set data bits for tx and rx, reset zero
// [RULE_20] stop 1 bit; bit 2 set gives 1.5 for five bits, else 2
// [RULE_21] word length 00 five, 01 six, 10 seven, 11 eight
// [RULE_22] after a clearing read the remaining sources are re-ranked
// [RULE_23] interrupt output follows id bit 0 inverted
//
// The register addresses and the strobed register port are this design's own decisions.
`include "uart_isr_lcr_consts.vh"
module uart_irq_status_line_format (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [6:0] src_event_i,
  input wire xon_rx_i,
  input wire tx_serial_i,
  input wire [7:0] par_data_i,
  input wire [7:0] rx_data_i,
  input wire rx_par_bit_i,
  output wire tx_line_o,
  output wire par_bit_o,
  output wire par_err_o,
  output wire par_en_o,
  output wire [3:0] data_bits_o,
  output wire [1:0] stop_half_o,
  output wire div_access_o,
  output wire irq_o
);

  // ==========================================================
  // registers
  reg [7:0] line_format_control;
  reg [7:0] enhanced_feature_reg;
  reg [7:0] src_enable;
  reg fifo_enabled;
  reg [6:0] pending;
  reg xoff_hold;
  reg [2:0] cur_src;
  reg cur_valid;

  // next values, one per register
  reg [7:0] next_line_format_control;
  reg [7:0] next_enhanced_feature_reg;
  reg [7:0] next_src_enable;
  reg next_fifo_enabled;
  wire [6:0] next_pending;
  reg next_xoff_hold;
  reg [2:0] next_cur_src;
  reg next_cur_valid;
  reg [7:0] next_rdata;

  // ==========================================================
  // access decode
  wire enh;
  wire feat_open;
  wire id_read;
  wire fmt_write;
  wire feat_write;
  wire src_en_write;
  wire fifo_write;

  assign enh = enhanced_feature_reg[`ENH_FEAT_BIT]; // [RULE_09]
  assign feat_open = line_format_control[`LFC_DIV_EN]; // [RULE_13]
  assign id_read = rd_i && (addr_i == `ADDR_INT_ID);
  assign fmt_write = wr_i && (addr_i == `ADDR_LINE_FMT);
  // the enhanced register stays shut unless format bit 7 is set
  assign feat_write = wr_i && (addr_i == `ADDR_EN_FEAT) && feat_open; // [RULE_13]
  assign src_en_write = wr_i && (addr_i == `ADDR_SRC_EN);
  assign fifo_write = wr_i && (addr_i == `ADDR_FIFO_EN);

  // ==========================================================
  // per-source eligibility and pending flags
  wire [6:0] enh_gate;
  wire [6:0] eligible;
  wire [6:0] clr_mask;
  wire [6:0] ranked;
  genvar s;
  generate
    for (s = 0; s < `NUM_SRC; s = s + 1) begin : g_src
      localparam [2:0] IDX = s;
      // enhanced sources are masked out entirely when enhancement is off
      if (s >= `SRC_XOFF) begin : g_enh
        assign enh_gate[s] = enh; // [RULE_09]
      end else begin : g_std
        assign enh_gate[s] = 1'b1;
      end
      assign eligible[s] = pending[s] & src_enable[s] & enh_gate[s];
      // only the reported source is cleared by an id read
      assign clr_mask[s] = id_read & cur_valid & (cur_src == IDX); // [RULE_03]
      // a new event wins over the clear in the same cycle
      assign next_pending[s] = (pending[s] & ~clr_mask[s]) | src_event_i[s];
      // the cleared source takes no part in the ranking, so reads may run back to back
      assign ranked[s] = eligible[s] & ~clr_mask[s]; // [RULE_22]
    end
  endgenerate

  // ==========================================================
  // priority ranking, source 0 highest
  reg [2:0] top_src;
  reg top_valid;
  integer i;
  always @* begin
    top_src = 3'h0;
    top_valid = 1'b0;
    for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (ranked[i]) begin
        top_src = i[2:0]; // [RULE_01]
        top_valid = 1'b1;
      end
    end
  end

  // ==========================================================
  // reported source
  wire cur_gone;
  // a masked or disabled source gives way without a read
  assign cur_gone = !eligible[cur_src];

  always @* begin
    next_cur_src = cur_src; // [RULE_02]
    next_cur_valid = cur_valid;
    if (id_read || !cur_valid) begin
      next_cur_src = top_src; // [RULE_22]
      next_cur_valid = top_valid;
    end else if (cur_gone) begin
      next_cur_src = top_src;
      next_cur_valid = top_valid;
    end
  end

  // hold survives id reads; only an xon lets it go
  always @* begin
    next_xoff_hold = xoff_hold;
    if (src_event_i[`SRC_XOFF]) begin
      next_xoff_hold = 1'b1;
    end else if (xon_rx_i) begin
      next_xoff_hold = 1'b0; // [RULE_10]
    end
  end

  // ==========================================================
  // identification value
  reg [5:0] cur_code;
  always @* begin
    case (cur_src)
      3'h0: cur_code = `CODE_LINE_ERR; // [RULE_04]
      3'h1: cur_code = `CODE_RX_DATA; // [RULE_05]
      3'h2: cur_code = `CODE_RX_TIMEOUT; // [RULE_05]
      3'h3: cur_code = `CODE_TX_EMPTY; // [RULE_06]
      3'h4: cur_code = `CODE_MODEM; // [RULE_06]
      3'h5: cur_code = `CODE_XOFF; // [RULE_07]
      3'h6: cur_code = `CODE_FLOW; // [RULE_08]
      default: cur_code = `CODE_MODEM;
    endcase
  end

  wire [5:0] xoff_bits;
  wire [5:0] base_code;
  wire [5:0] id_bits;
  wire [7:0] id_value;

  // xoff bit shows while held, only in enhanced mode
  assign xoff_bits = (xoff_hold && enh) ? `CODE_XOFF : `CODE_CLEAR; // [RULE_10]
  assign base_code = cur_valid ? cur_code : `CODE_NONE; // [RULE_12]
  assign id_bits = base_code | xoff_bits;
  assign id_value = {fifo_enabled, fifo_enabled, id_bits}; // [RULE_11]

  // ==========================================================
  // register writes
  always @* begin
    next_line_format_control = line_format_control;
    if (fmt_write) begin
      next_line_format_control = wdata_i;
    end
  end

  always @* begin
    next_enhanced_feature_reg = enhanced_feature_reg;
    if (feat_write) begin
      next_enhanced_feature_reg = wdata_i; // [RULE_13]
    end
  end

  always @* begin
    next_src_enable = src_enable;
    if (src_en_write) begin
      next_src_enable = wdata_i;
    end
  end

  always @* begin
    next_fifo_enabled = fifo_enabled;
    if (fifo_write) begin
      next_fifo_enabled = wdata_i[`FIFO_EN_BIT];
    end
  end

  // ==========================================================
  // register reads
  wire [7:0] feat_view;
  wire [7:0] fifo_view;

  assign feat_view = feat_open ? enhanced_feature_reg : `RDATA_IDLE; // [RULE_13]
  assign fifo_view = {7'h00, fifo_enabled};

  // read data stands for one cycle only, idle otherwise
  always @* begin
    next_rdata = `RDATA_IDLE;
    if (rd_i) begin
      case (addr_i)
        `ADDR_INT_ID: next_rdata = id_value; // [RULE_01]
        `ADDR_LINE_FMT: next_rdata = line_format_control;
        `ADDR_EN_FEAT: next_rdata = feat_view;
        `ADDR_SRC_EN: next_rdata = src_enable;
        `ADDR_FIFO_EN: next_rdata = fifo_view;
        default: next_rdata = `RDATA_IDLE;
      endcase
    end
  end

  // ==========================================================
  // state flip-flops
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_format_control <= `LFC_RESET; // [RULE_18] [RULE_19]
    end else begin
      line_format_control <= next_line_format_control;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enhanced_feature_reg <= `ENH_FEAT_RESET;
    end else begin
      enhanced_feature_reg <= next_enhanced_feature_reg;
    end
  end

  // no source is ranked until software enables it; the held xoff bit shows once the enhanced bit is set
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_enable <= `SRC_EN_RESET;
    end else begin
      src_enable <= next_src_enable;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_enabled <= `FIFO_RESET;
    end else begin
      fifo_enabled <= next_fifo_enabled;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending <= 7'h00;
    end else begin
      pending <= next_pending;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xoff_hold <= 1'b0;
    end else begin
      xoff_hold <= next_xoff_hold;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_src <= 3'h0;
      cur_valid <= 1'b0;
    end else begin
      cur_src <= next_cur_src;
      cur_valid <= next_cur_valid;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `RDATA_IDLE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // line format decode
  wire [1:0] wlen;
  reg [3:0] data_bits;
  reg [1:0] stop_half;

  assign wlen = line_format_control[`LFC_WLEN_HI:`LFC_WLEN_LO];

  always @* begin
    case (wlen)
      `WLEN_5: data_bits = `DBITS_5; // [RULE_21]
      `WLEN_6: data_bits = `DBITS_6;
      `WLEN_7: data_bits = `DBITS_7;
      default: data_bits = `DBITS_8;
    endcase
  end

  always @* begin
    if (!line_format_control[`LFC_STOP]) begin
      stop_half = `STOP_HALF_1; // [RULE_20]
    end else if (wlen == `WLEN_5) begin
      stop_half = `STOP_HALF_15;
    end else begin
      stop_half = `STOP_HALF_2;
    end
  end

  wire break_on;
  assign break_on = line_format_control[`LFC_BREAK];
  assign data_bits_o = data_bits; // [RULE_19]
  assign stop_half_o = stop_half; // [RULE_18]
  assign par_en_o = line_format_control[`LFC_PAR_EN]; // [RULE_17]
  assign div_access_o = feat_open; // [RULE_13]
  // break wins over whatever the shifter is sending
  assign tx_line_o = tx_serial_i & ~break_on; // [RULE_14]

  // ==========================================================
  // parity
  wire [7:0] word_mask;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      localparam [3:0] POS = b;
      // bits beyond the word length take no part in the count
      assign word_mask[b] = (data_bits > POS); // [RULE_16]
    end
  endgenerate

  wire [7:0] tx_word;
  wire [7:0] rx_word;
  wire even;
  wire forced;
  wire tx_ones;
  wire rx_ones;
  wire tx_par;
  wire rx_exp;

  assign tx_word = par_data_i & word_mask;
  assign rx_word = rx_data_i & word_mask;
  assign even = line_format_control[`LFC_EVEN];
  assign forced = line_format_control[`LFC_FORCE];
  assign tx_ones = ^tx_word;
  assign rx_ones = ^rx_word;
  // odd parity: the bit makes the total count of ones odd
  assign tx_par = forced ? ~even : (even ? tx_ones : ~tx_ones); // [RULE_15] [RULE_16]
  assign rx_exp = forced ? ~even : (even ? rx_ones : ~rx_ones); // [RULE_15] [RULE_16]
  // both outputs rest low while parity is off
  assign par_bit_o = par_en_o & tx_par; // [RULE_17]
  assign par_err_o = par_en_o & (rx_exp ^ rx_par_bit_i); // [RULE_17]

  assign irq_o = ~id_value[0]; // [RULE_23]

endmodule

// ==== isr_lcr_monitor.sv ====
// concurrent checks on the identification and line format ports
module id_format_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic tx_serial_i,
  input wire logic tx_line_o,
  input wire logic par_en_o,
  input wire logic par_bit_o,
  input wire logic par_err_o,
  input wire logic [3:0] data_bits_o,
  input wire logic [1:0] stop_half_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // assertions
  sequence id_rd;
    rd_i && addr_i == 3'h2;
  endsequence
  brk_pass_a: assert property (!tx_serial_i |-> !tx_line_o)
    else $error("tx line high while serial data low");
  irq_bit_a: assert property (id_rd |=> rdata_o[0] == !$past(irq_o))
    else $error("irq output disagrees with id bit 0");
  fifo_pair_a: assert property (id_rd |=> rdata_o[7] == rdata_o[6])
    else $error("id bits 7 and 6 differ");
  code_legal_a: assert property (id_rd |=> rdata_o[3:0] inside {6, 4, 12, 2, 0, 1})
    else $error("illegal id code");
  par_off_a: assert property (!par_en_o |-> !par_bit_o && !par_err_o)
    else $error("parity active while disabled");
  wlen_range_a: assert property (data_bits_o inside {[5:8]})
    else $error("word length out of range");
  stop_len_a: assert property (stop_half_o == 2'h3 |-> data_bits_o == 4'h5)
    else $error("half stop bit on long word");
  fmt_hold_a: assert property (!$past(wr_i) |-> $stable(data_bits_o))
    else $error("word length moved without write");
  cover property (tx_serial_i && !tx_line_o);
  cover property (id_rd ##1 !rdata_o[0]);
  cover property (par_err_o);
endmodule
bind uart_irq_status_line_format id_format_monitor mon_u (.*);

// ==== line_peer.sv ====
// remote serial device: sends parity with each byte, watches for break
module line_peer (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic [7:0] data_i,
  input wire logic odd_i,
  output logic par_o,
  output logic brk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_cnt = 5'h00;
  // ====
  // odd_i flips the sum so the bench picks any parity format
  assign par_o = ^data_i ^ odd_i;
  // break seen once the line stays low for 16 cycles
  always @(posedge clk_i) low_cnt <= line_i ? 5'h00 : low_cnt + {4'h0, !low_cnt[4]};
  assign brk_o = low_cnt[4];
endmodule

// ==== tb_top.sv ====
// self-checking bench for the identification and line format block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, xon_rx_i = 0, tx_serial_i = 1, odd = 0;
  logic [2:0] addr_i = 0;
  logic [7:0] wdata_i = 0, par_data_i = 8'h03;
  logic [6:0] src_event_i = 0;
  wire [7:0] rdata_o;
  wire tx_line_o, par_bit_o, par_err_o, par_en_o, div_access_o, irq_o, rx_par_bit_i, brk;
  wire [3:0] data_bits_o;
  wire [1:0] stop_half_o;
  int n_errors = 0, tests_run = 0;
  logic [7:0] codes [7] = '{8'h06, 8'h04, 8'h0c, 8'h02, 8'h00, 8'h20, 8'h01};
  uart_irq_status_line_format dut_u (.*, .rx_data_i(par_data_i));
  line_peer peer_u (.clk_i, .line_i(tx_line_o), .data_i(par_data_i), .odd_i(odd),
    .par_o(rx_par_bit_i), .brk_o(brk));
  initial forever #4 clk_i = ~clk_i;
  // ====
  // bus and compare helpers
  task chk(input logic [7:0] s, input logic [7:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) wr_i <= 0;
    #1;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i) rd_i <= 0;
    #1 chk(rdata_o, e, n);
  endtask
  task ev(input logic [6:0] m);
    @(posedge clk_i) src_event_i <= m;
    @(posedge clk_i) src_event_i <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  // ====
  // scenarios
  task t_regs;
    rd(3'h3, 8'h00, "format");
    rd(3'h2, 8'h01, "id reset");
    rd(3'h4, 8'h00, "enh closed");
    rd(3'h7, 8'h00, "unmapped");
    wr(3'h3, 8'h80);
    chk(div_access_o, 1, "div access");
    wr(3'h4, 8'h10);
    rd(3'h4, 8'h10, "enh open");
    wr(3'h3, 8'h00);
  endtask
  task t_prio;
    wr(3'h5, 8'h7f);
    ev(7'h5f);
    chk(irq_o, 1, "irq");
    foreach (codes[i]) rd(3'h2, codes[i], "id order");
    ev(7'h20);
    rd(3'h2, 8'h10, "xoff");
    rd(3'h2, 8'h11, "xoff held");
    @(posedge clk_i) xon_rx_i <= 1;
    @(posedge clk_i) xon_rx_i <= 0;
    rd(3'h2, 8'h01, "xon");
    wr(3'h6, 8'h01);
    rd(3'h2, 8'hc1, "fifo bits");
    wr(3'h6, 8'h00);
    ev(7'h08);
    ev(7'h01);
    rd(3'h2, 8'h02, "id held");
    rd(3'h2, 8'h06, "id next");
    rd(3'h2, 8'h01, "id drained");
    wr(3'h3, 8'h80);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h00);
    ev(7'h60);
    rd(3'h2, 8'h01, "enh off");
    chk(irq_o, 0, "irq idle");
  endtask
  task t_fmt;
    for (int i = 0; i < 8; i++) begin
      wr(3'h3, 8'(i));
      chk(data_bits_o, 8'(5 + i % 4), "word bits");
      chk(stop_half_o, i < 4 ? 8'h02 : i == 4 ? 8'h03 : 8'h00, "stop");
    end
    for (int i = 0; i < 4; i++) begin
      odd = !i[0];
      wr(3'h3, 8'h0b | 8'(i << 4));
      chk({par_en_o, par_bit_o, par_err_o}, {5'h00, 1'b1, odd, 1'b0}, "parity");
      odd = i[0];
      #1 chk(par_err_o, 1, "parity err");
    end
  endtask
  task t_brk;
    wr(3'h3, 8'h40);
    repeat (20) @(posedge clk_i);
    chk({tx_line_o, brk}, 8'h01, "break");
    wr(3'h3, 8'h00);
    chk(tx_line_o, 1, "break off");
  endtask
  task final_report;
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    t_prio;
    t_fmt;
    t_brk;
    final_report;
  end
endmodule
